// ===== src/wrc_cfg.svh
/*
 * wrc_cfg.svh - register offsets, field positions, reset values and timing
 * constants of the wrapping real-time counter.
 * assumes: included by its bare name from the package and the design file.
 */
`ifndef WRC_CFG_SVH
`define WRC_CFG_SVH

// register byte offsets
`define WRC_OFS_CTRL 8'h00
`define WRC_OFS_VALUE 8'h04
`define WRC_OFS_LIMIT 8'h08
`define WRC_OFS_IER 8'h10
`define WRC_OFS_IDR 8'h14
`define WRC_OFS_IMR 8'h18
`define WRC_OFS_ISR 8'h1c
`define WRC_OFS_ICR 8'h20

// counter_control field positions
`define WRC_CTRL_EN 0
`define WRC_CTRL_PRESCALER_CLEAR_STROBE 1
`define WRC_CTRL_WAKE 2
`define WRC_CTRL_SLOW 3
`define WRC_CTRL_BUSY 4
`define WRC_CTRL_PSEL_LO 8
`define WRC_CTRL_PSEL_HI 11
`define WRC_CTRL_SOURCE_CLOCK_GATE 16

// interrupt bit position
`define WRC_IRQ_WRAP 0

// reset values
`define WRC_RST_WORD 32'h0000_0000

// cycles a control, value or limit write keeps busy high
`define WRC_BUSY_CYCLES 3'h4

`endif

// ===== src/wrc_pkg.sv
/*
 * wrc_pkg.sv - types shared by the wrapping real-time counter.
 * assumes: wrc_cfg.svh on the include path.
 */
`default_nettype none
`include "wrc_cfg.svh"
package wrc_pkg;
    typedef enum logic [1:0] {
        WRC_IDLE,
        WRC_DATA
    } wrc_bus_e;
    typedef logic [31:0] wrc_word_t;
endpackage
`default_nettype wire

// ===== src/wrc_counter.sv
/*
 * wrc_counter.sv - 32-bit wrapping real-time counter with a 16-bit
 * prescaler, wrap interrupt and direct wake, behind an AHB-Lite slave.
 * assumes: one clock hclk; rc_osc_tick and slow_osc_tick are one-hclk
 * pulses per oscillator edge, synchronous to hclk; hsel decoded outside.
 */
// Decided for this implementation: register access over AHB-Lite.
`default_nettype none
`include "wrc_cfg.svh"

////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - source clock gate bit 0 stops prescaler clock, 1 lets it run
// - prescaler bit chosen by tap select advances the counter
// - while busy, writes to control, value and limit are dropped
// - oscillator select 0 picks RC oscillator, 1 picks 32 kHz oscillator
// - wake request raised on wrap only when wake enable is 1
// - writing 1 to prescaler clear zeroes prescaler; bit not stored
// - counter runs only while enable bit is 1
// - count value increments on each selected clock rising edge, read/write
// - count wraps when it reaches the wrap limit
// - each wrap recorded in wrap event flag, bit 0 of irq registers
// - enable-set writes set mask, enable-clear clears it, mask readable
// - status register reports wrap flag, read as 1 meaning event occurred
// - writing 1 to event clear clears the wrap flag; 0 no effect
// - at the limit the count returns to zero and flag is set
// - interrupt output high while flag set and interrupt enabled
// - 16-bit prescaler advances on each edge of the selected oscillator while enable and clock gate bits are 1, not accessible
module wrc_counter
    import wrc_pkg::*;
#(
    parameter int PRE_W = 16
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // oscillator edges
    input wire logic rc_osc_tick,
    input wire logic slow_osc_tick,
    // system outputs
    output logic irq,
    output logic wake_req
);

    ////////////////////////////////////////////////////////////////////////
    // bus address phase capture

    wrc_bus_e bus_state;
    logic [7:0] wr_addr;
    logic wr_pend;
    logic [7:0] rd_addr;

    logic addr_take;
    assign addr_take = hsel && hready && htrans[1];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_state <= WRC_IDLE;
        end else begin
            bus_state <= addr_take ? WRC_DATA : WRC_IDLE;
        end
    end

    // write data arrives one cycle later, so the write is flagged for the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
        end else begin
            wr_pend <= addr_take && hwrite;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_addr <= 8'h00;
        end else if (addr_take) begin
            wr_addr <= haddr[7:0];
        end
    end
    assign rd_addr = haddr[7:0];

    ////////////////////////////////////////////////////////////////////////
    // registers

    logic ctl_en;
    logic ctl_wake;
    logic ctl_slow;
    logic ctl_gate;
    logic [3:0] ctl_psel;
    logic [31:0] count_value;
    logic [31:0] wrap_limit;
    logic irq_mask_state;
    logic wrap_event_flag;
    logic [2:0] busy_cnt;
    logic busy;
    logic [PRE_W-1:0] prescaler;
    logic [PRE_W-1:0] pre_hist;

    assign busy = (busy_cnt != 3'h0);

    logic wr_ctrl;
    logic wr_val;
    logic wr_lim;
    logic wr_ok;
    assign wr_ok = wr_pend && !busy;
    assign wr_ctrl = wr_ok && (wr_addr == `WRC_OFS_CTRL);
    assign wr_val = wr_ok && (wr_addr == `WRC_OFS_VALUE);
    assign wr_lim = wr_ok && (wr_addr == `WRC_OFS_LIMIT);

    // busy models the hop into the counter domain after each accepted control, value or limit write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy_cnt <= 3'h0;
        end else if (wr_ctrl || wr_val || wr_lim) begin
            busy_cnt <= `WRC_BUSY_CYCLES;
        end else if (busy) begin
            busy_cnt <= busy_cnt - 3'h1;
        end
    end

    // control register; reserved bits never stored
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctl_en <= 1'b0;
            ctl_wake <= 1'b0;
            ctl_slow <= 1'b0;
            ctl_gate <= 1'b0;
            ctl_psel <= 4'h0;
        end else if (wr_ctrl) begin
            ctl_en <= hwdata[`WRC_CTRL_EN];
            ctl_wake <= hwdata[`WRC_CTRL_WAKE];
            ctl_slow <= hwdata[`WRC_CTRL_SLOW];
            ctl_gate <= hwdata[`WRC_CTRL_SOURCE_CLOCK_GATE];
            ctl_psel <= hwdata[`WRC_CTRL_PSEL_HI:`WRC_CTRL_PSEL_LO];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // prescaler and counter

    logic osc_tick;
    logic pre_run;
    logic tap_now;
    logic cnt_edge;
    logic at_limit;
    assign osc_tick = ctl_slow ? slow_osc_tick : rc_osc_tick;
    assign pre_run = ctl_en && ctl_gate && osc_tick;
    assign tap_now = prescaler[ctl_psel];
    // edge taken on the same tap of the previous prescaler value, so a
    // change of tap select cannot fake a count edge
    assign cnt_edge = ctl_en && tap_now && !pre_hist[ctl_psel];
    assign at_limit = (count_value == wrap_limit);

    // clear strobe acts on the write and leaves nothing stored
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prescaler <= '0;
        end else if (wr_ctrl && hwdata[`WRC_CTRL_PRESCALER_CLEAR_STROBE]) begin
            prescaler <= '0;
        end else if (pre_run) begin
            prescaler <= prescaler + 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pre_hist <= '0;
        end else begin
            pre_hist <= prescaler;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_value <= `WRC_RST_WORD;
        end else if (wr_val) begin
            count_value <= hwdata;
        end else if (cnt_edge) begin
            if (at_limit) begin
                count_value <= `WRC_RST_WORD;
            end else begin
                count_value <= count_value + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wrap_limit <= `WRC_RST_WORD;
        end else if (wr_lim) begin
            wrap_limit <= hwdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt and wake

    logic wrap_ev;
    assign wrap_ev = cnt_edge && at_limit && !wr_val;

    // interrupt registers are not subject to busy
    logic wr_ier;
    logic wr_idr;
    logic wr_icr;
    assign wr_ier = wr_pend && (wr_addr == `WRC_OFS_IER) && hwdata[`WRC_IRQ_WRAP];
    assign wr_idr = wr_pend && (wr_addr == `WRC_OFS_IDR) && hwdata[`WRC_IRQ_WRAP];
    assign wr_icr = wr_pend && (wr_addr == `WRC_OFS_ICR) && hwdata[`WRC_IRQ_WRAP];

    logic next_mask;
    always_comb begin
        next_mask = irq_mask_state;
        if (wr_ier) begin
            next_mask = 1'b1;
        end else if (wr_idr) begin
            next_mask = 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_mask_state <= 1'b0;
        end else begin
            irq_mask_state <= next_mask;
        end
    end

    // a wrap in the clearing cycle wins over the clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wrap_event_flag <= 1'b0;
        end else if (wrap_ev) begin
            wrap_event_flag <= 1'b1;
        end else if (wr_icr) begin
            wrap_event_flag <= 1'b0;
        end
    end

    logic next_flag;
    assign next_flag = wrap_ev || (wrap_event_flag && !wr_icr);

    // irq registered from the next-state terms so it tracks the flag exactly
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= next_flag && next_mask;
        end
    end

    // wake stays high until software drops wake enable
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wake_req <= 1'b0;
        end else if (!ctl_wake) begin
            wake_req <= 1'b0;
        end else if (wrap_ev) begin
            wake_req <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data and response

    logic [31:0] next_rdata;
    always_comb begin
        next_rdata = `WRC_RST_WORD;
        case (rd_addr)
            `WRC_OFS_CTRL: begin
                next_rdata[`WRC_CTRL_EN] = ctl_en;
                next_rdata[`WRC_CTRL_WAKE] = ctl_wake;
                next_rdata[`WRC_CTRL_SLOW] = ctl_slow;
                next_rdata[`WRC_CTRL_BUSY] = busy;
                next_rdata[`WRC_CTRL_PSEL_HI:`WRC_CTRL_PSEL_LO] = ctl_psel;
                next_rdata[`WRC_CTRL_SOURCE_CLOCK_GATE] = ctl_gate;
            end
            `WRC_OFS_VALUE: next_rdata = count_value;
            `WRC_OFS_LIMIT: next_rdata = wrap_limit;
            `WRC_OFS_IMR: next_rdata[`WRC_IRQ_WRAP] = irq_mask_state;
            `WRC_OFS_ISR: next_rdata[`WRC_IRQ_WRAP] = wrap_event_flag;
            // write-only registers read back as zero
            `WRC_OFS_IER: next_rdata = `WRC_RST_WORD;
            `WRC_OFS_IDR: next_rdata = `WRC_RST_WORD;
            `WRC_OFS_ICR: next_rdata = `WRC_RST_WORD;
            default: next_rdata = `WRC_RST_WORD;
        endcase
    end

    // zero-wait slave: read data registered at the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= `WRC_RST_WORD;
        end else begin
            hrdata <= (addr_take && !hwrite) ? next_rdata : `WRC_RST_WORD;
        end
    end

    // no wait states: every register answers in one cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
        end else begin
            hreadyout <= 1'b1;
        end
    end

    // dropped busy writes still answer okay
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// ===== tb/wrc_counter_sva.sv
/* wrc_counter_sva.sv - port assertions for wrc_counter.
 * assumes: bound to wrc_counter, one hclk domain. */
`default_nettype none
module wrc_counter_sva (
    // bus side
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // oscillators and outputs
    input wire logic rc_osc_tick,
    input wire logic slow_osc_tick,
    input wire logic irq,
    input wire logic wake_req
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic rd;
    logic wr;
    logic [7:0] ad;
    wire tk = rc_osc_tick | slow_osc_tick;
    ////////////////////////////////////////
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd <= 1'b0;
            wr <= 1'b0;
            ad <= 8'h00;
        end else begin
            rd <= hsel & hready & htrans[1] & !hwrite;
            wr <= hsel & hready & htrans[1] & hwrite;
            ad <= haddr[7:0];
        end
    end
    ////////////////////////////////////////
    a_resp_okay: assert property (hresp == 1'b0) else $error("error response");
    a_ready_high: assert property (hreadyout) else $error("wait state");
    a_rdata_idle: assert property (!rd |-> hrdata == 32'h0000_0000) else $error("stray read data");
    a_ctrl_resv: assert property (rd && ad == 8'h00 |-> (hrdata & 32'hfffe_f0e2) == 32'h0000_0000)
        else $error("control reserved bits");
    a_irq_resv: assert property (rd && (ad == 8'h18 || ad == 8'h1c) |-> hrdata[31:1] == 31'h0)
        else $error("irq reserved bits");
    a_unmapped_zero: assert property (rd && ad == 8'h0c |-> hrdata == 32'h0000_0000)
        else $error("unmapped read");
    a_disable_irq: assert property (wr && ad == 8'h14 && hwdata[0] |-> ##2 !irq)
        else $error("irq after disable");
    a_clear_irq: assert property (wr && ad == 8'h20 && hwdata[0] && !tk && !$past(tk) && !$past(tk, 2) |-> ##2 !irq)
        else $error("irq after clear");
    c_busy: cover property (rd && ad == 8'h00 && hrdata[4]);
    c_irq: cover property ($rose(irq));
    c_wake: cover property ($rose(wake_req));
endmodule
bind wrc_counter wrc_counter_sva u_wrc_counter_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .rc_osc_tick(rc_osc_tick), .slow_osc_tick(slow_osc_tick), .irq(irq), .wake_req(wake_req));
`default_nettype wire

// ===== tb/test_wrc_counter.sv
/* test_wrc_counter.sv - self-checking bench with a reference model.
 * assumes: wrc_counter and its checker compiled first. */
`default_nettype none
module test_wrc_counter;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0, rct = 1'b0, slt = 1'b0;
    logic hreadyout, hresp, irq, wake_req;
    logic [15:0] pre = 16'h0;
    logic [31:0] val = 32'h0, lim = 32'h0, cr = 32'h0;
    logic fl = 1'b0, msk = 1'b0, wq = 1'b0;
    logic [7:0] offs [6] = '{8'h00, 8'h04, 8'h08, 8'h18, 8'h1c, 8'h0c};
    int err_total, comparisons, cyc;
    always #5 hclk = ~hclk;
    wrc_counter u_wrc_counter (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .rc_osc_tick(rct), .slow_osc_tick(slt), .irq(irq), .wake_req(wake_req));
    ////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), q, e);
    endtask
    // waits out busy so the model never guesses at dropped writes
    task automatic wc(input logic [31:0] d);
        bus(1'b1, 8'h00, d);
        repeat (5) @(posedge hclk);
        if (d[1]) pre = 16'h0;
        cr = d & 32'h0001_0f0d;
        if (!cr[2]) wq = 1'b0;
        rd(8'h00, cr);
    endtask
    task automatic tick(input logic s, input int n);
        logic o;
        repeat (n) begin
            if (s) slt <= 1'b1;
            else rct <= 1'b1;
            @(posedge hclk);
            rct <= 1'b0;
            slt <= 1'b0;
            @(posedge hclk);
            if (cr[0] && cr[16] && s == cr[3]) begin
                o = pre[cr[11:8]];
                pre = pre + 16'h1;
                if (!o && pre[cr[11:8]]) begin
                    if (val == lim) begin
                        val = 32'h0;
                        fl = 1'b1;
                        wq = wq | cr[2];
                    end else val = val + 32'h1;
                end
            end
        end
        repeat (4) @(posedge hclk);
        chk("irq", irq, fl & msk);
        chk("wake", wake_req, wq);
    endtask
    task give_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            give_verdict;
        end
    end
    ////////////////////////////////////////
    initial begin
        void'($urandom(42));
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        foreach (offs[i]) rd(offs[i], 32'h0);
        bus(1'b1, 8'h08, 32'h3);
        bus(1'b1, 8'h04, 32'h7);
        rd(8'h00, 32'h10);
        lim = 32'h3;
        repeat (6) @(posedge hclk);
        rd(8'h04, 32'h0);
        rd(8'h08, lim);
        bus(1'b1, 8'h10, 32'h1);
        msk = 1'b1;
        rd(8'h18, 32'h1);
        wc(32'h0001_0005);
        tick(1'b0, 8);
        rd(8'h1c, {31'h0, fl});
        tick(1'b1, 3);
        rd(8'h04, val);
        wc(32'h0001_0001);
        tick(1'b0, 0);
        bus(1'b1, 8'h20, 32'h1);
        fl = 1'b0;
        tick(1'b0, 0);
        wc(32'h0001_0101);
        tick(1'b0, 3);
        wc(32'h0001_0103);
        tick(1'b0, 2);
        rd(8'h04, val);
        repeat (10) begin
            wc($urandom & 32'h0001_030d);
            msk = 1'($urandom);
            bus(1'b1, msk ? 8'h10 : 8'h14, 32'h1);
            tick(1'($urandom), $urandom_range(1, 12));
            rd(8'h04, val);
            bus(1'b1, 8'h20, 32'h1);
            fl = 1'b0;
        end
        give_verdict;
    end
endmodule
`default_nettype wire
